// File: design/timer8_pkg.sv
package timer8_pkg;

    // Register byte offsets on the APB bus
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_COUNT   = 8'h04;
    localparam logic [7:0] OFF_COMPARE = 8'h08;
    localparam logic [7:0] OFF_FLAGS   = 8'h0C;
    localparam logic [7:0] OFF_IRQ_EN  = 8'h10;
    localparam logic [7:0] OFF_PORT    = 8'h14;

    // Field positions
    localparam int CTRL_FORCE_BIT = 9;
    localparam int FLAG_CMP_BIT   = 0;
    localparam int FLAG_OVF_BIT   = 1;
    localparam int EN_CMP_BIT     = 0;
    localparam int EN_OVF_BIT     = 1;
    localparam int PORT_VAL_BIT   = 0;
    localparam int PORT_DIR_BIT   = 1;

    // Counter landmarks and reset values
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_MAX    = 8'hFF;
    localparam logic [7:0] CNT_ONE    = 8'h01;
    localparam logic [2:0] CS_STOP    = 3'h0;

    // Waveform mode encodings
    localparam logic [1:0] WGM_NORMAL = 2'h0;
    localparam logic [1:0] WGM_PCPWM  = 2'h1;
    localparam logic [1:0] WGM_CTC    = 2'h2;
    localparam logic [1:0] WGM_FAST   = 2'h3;

    // Compare output mode encodings
    localparam logic [1:0] COM_OFF    = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR  = 2'h2;
    localparam logic [1:0] COM_SET    = 2'h3;

    // Control register layout, bits 8:0
    typedef struct packed {
        logic       async_clock_select;
        logic       spare;                      // Bit 7, no function
        logic [1:0] compare_output_mode_field;
        logic [1:0] waveform_mode_field;
        logic [2:0] clock_select_field;
    } ctrl_s;

    localparam ctrl_s CTRL_RESET = '0;

    // Count direction, one-hot
    typedef enum logic [1:0] {
        DIR_UP   = 2'b01,
        DIR_DOWN = 2'b10
    } dir_e;

endpackage

// File: design/timer8.sv
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
// Behaviour
// - Timer tick follows pclk by default, crystal pin edges when async select is one.
// - Clock select zero stops the counter: no count, no clear.
// - Software can read and write the count at all times.
// - A count write beats any clear or step in the same cycle.
// - Count sequence and overflow timing depend on the waveform mode field and, in clear-on-match mode, the compare value.
// - Count equal to compare sets the compare flag on the next tick.
// - Compare flag with enable requests interrupt; cleared by acknowledge or write one.
// - Compare value is double buffered in PWM modes, updated at top; direct otherwise.
// - Compare writes reach the buffer when buffered, the active value otherwise.
// - Force strobe in non-PWM modes acts on output only, no flag, no counter change.
// - Any count write suppresses compare matches on the next tick, even stopped.
// - Internal compare output keeps its value across waveform mode changes.
// - Compare output mode is not buffered; new value governs the next match.
// - Nonzero output mode puts compare output on the pin; direction stays the port's.
// - Output mode zero leaves the compare output unchanged on matches.
// - Non-PWM: set, clear or toggle on match; PWM: inverted or non-inverted output.
// - Normal mode only increments and wraps from FF to 00.
// - Normal mode sets overflow as count becomes zero; acknowledge clears it.
// - Normal mode accepts a new count at any time.
// - Compare output can be set before the pin driver is enabled.
// - Clear-on-match mode clears the count when it equals the compare value.
// - Fast PWM counts zero to FF, then restarts from zero.
// - Phase-correct PWM counts up to FF, then back down to zero.
module timer8
    import timer8_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Crystal oscillator input
    input  wire logic              crystal_in_pin,
    // Interrupt requests and acknowledges
    input  wire logic              compare_irq_ack,
    input  wire logic              overflow_irq_ack,
    output logic                   compare_irq,
    output logic                   overflow_irq,
    // Compare output pin driver
    output logic                   compare_output_pin,
    output logic                   compare_output_pin_oe
);

    // Registers
    ctrl_s       ctrl_ff;
    dir_e        dir_ff;
    logic [7:0]  count_value_ff;
    logic [7:0]  compare_value_ff;
    logic [7:0]  compare_buf_ff;
    logic        compare_flag_ff;
    logic        overflow_flag_ff;
    logic        compare_irq_enable_ff;
    logic        overflow_irq_enable_ff;
    logic        port_val_ff;
    logic        pin_direction_bit_ff;
    logic        compare_output_ff;
    logic        block_ff;
    logic        xtal_meta_ff;
    logic        xtal_sync_ff;
    logic        xtal_prev_ff;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic        compare_irq_ff;
    logic        overflow_irq_ff;
    logic        pin_out_ff;
    logic        pin_oe_ff;

    // Bus decode
    wire         setup     = psel & ~penable;
    wire         access    = psel & penable & pready_ff;
    wire         wr        = access & pwrite;
    wire         hit_ctrl  = paddr == ADDR_W'(OFF_CTRL);
    wire         hit_count = paddr == ADDR_W'(OFF_COUNT);
    wire         hit_cmp   = paddr == ADDR_W'(OFF_COMPARE);
    wire         hit_flags = paddr == ADDR_W'(OFF_FLAGS);
    wire         hit_en    = paddr == ADDR_W'(OFF_IRQ_EN);
    wire         hit_port  = paddr == ADDR_W'(OFF_PORT);
    wire         mapped    = hit_ctrl | hit_count | hit_cmp | hit_flags | hit_en | hit_port;
    wire         wr_ctrl   = wr & hit_ctrl;
    wire         wr_count  = wr & hit_count;
    wire         wr_cmp    = wr & hit_cmp;
    wire         wr_flags  = wr & hit_flags;
    wire         wr_en     = wr & hit_en;
    wire         wr_port   = wr & hit_port;

    // Mode decode
    wire [1:0]   wgm       = ctrl_ff.waveform_mode_field;
    wire [1:0]   com       = ctrl_ff.compare_output_mode_field;
    wire         pwm       = (wgm == WGM_PCPWM) | (wgm == WGM_FAST);
    wire         at_max    = count_value_ff == CNT_MAX;
    wire         at_zero   = count_value_ff == CNT_BOTTOM;
    wire         match     = count_value_ff == compare_value_ff;

    // Timer tick source
    wire         xtal_rise = xtal_sync_ff & ~xtal_prev_ff;
    wire         src_tick  = ctrl_ff.async_clock_select ? xtal_rise : 1'b1;
    wire         tick      = (ctrl_ff.clock_select_field != CS_STOP) & src_tick;

    // Counter step per waveform mode
    wire         go_down   = (wgm == WGM_PCPWM) & (at_max | ((dir_ff == DIR_DOWN) & ~at_zero));
    wire [7:0]   cnt_inc   = 8'(count_value_ff + CNT_ONE);
    wire [7:0]   cnt_dec   = 8'(count_value_ff - CNT_ONE);
    wire         ctc_clear = (wgm == WGM_CTC) & match;
    wire [7:0]   cnt_step  = ctc_clear ? CNT_BOTTOM : (go_down ? cnt_dec : cnt_inc);
    wire [7:0]   nxt_count_value = wr_count ? pwdata[7:0] : (tick ? cnt_step : count_value_ff);

    // Events of one timer tick
    wire         match_ev  = tick & match & ~block_ff;
    wire         top_ev    = tick & at_max;
    wire         bottom_pc = go_down & (count_value_ff == CNT_ONE);
    wire         ovf_ev    = tick & ~wr_count & ((wgm == WGM_PCPWM) ? bottom_pc : at_max);
    wire ctrl_s  ctrl_wr   = ctrl_s'(pwdata[8:0]);
    wire [1:0]   wgm_wr    = ctrl_wr.waveform_mode_field;
    wire         pwm_wr    = (wgm_wr == WGM_PCPWM) | (wgm_wr == WGM_FAST);
    wire         force_hit = wr_ctrl & pwdata[CTRL_FORCE_BIT] & ~pwm_wr;

    // Flags, set wins over clear
    wire         nxt_compare_flag  = match_ev | (compare_flag_ff & ~compare_irq_ack
                                     & ~(wr_flags & pwdata[FLAG_CMP_BIT]));
    wire         nxt_overflow_flag = ovf_ev | (overflow_flag_ff & ~overflow_irq_ack
                                     & ~(wr_flags & pwdata[FLAG_OVF_BIT]));

    // Compare output action
    function automatic logic oc_action(input logic [1:0] mode, input logic cur);
        case (mode)
            COM_TOGGLE: oc_action = ~cur;
            COM_CLEAR:  oc_action = 1'b0;
            COM_SET:    oc_action = 1'b1;
            default:    oc_action = cur;
        endcase
    endfunction

    logic nxt_compare_output;

    // Waveform generator
    always_comb begin
        nxt_compare_output = compare_output_ff;
        case (wgm)
            WGM_NORMAL, WGM_CTC: begin
                if (match_ev) begin
                    nxt_compare_output = oc_action(com, compare_output_ff);
                end
            end
            WGM_FAST: begin
                if (match_ev) begin
                    nxt_compare_output = oc_action(com, compare_output_ff);
                end else if (top_ev & com[1]) begin
                    nxt_compare_output = ~com[0];
                end
            end
            WGM_PCPWM: begin
                if (match_ev & com[1]) begin
                    nxt_compare_output = com[0] ^ go_down;
                end
            end
            default: nxt_compare_output = compare_output_ff;
        endcase
        // Force acts with the output mode written alongside it
        if (force_hit) begin
            nxt_compare_output = oc_action(ctrl_wr.compare_output_mode_field, compare_output_ff);
        end
    end

    // Read data
    wire [31:0]  rd_ctrl  = {23'h0, ctrl_ff};
    wire [7:0]   rd_cmp   = pwm ? compare_buf_ff : compare_value_ff;
    wire [31:0]  rd_data  = hit_ctrl  ? rd_ctrl :
                            hit_count ? {24'h0, count_value_ff} :
                            hit_cmp   ? {24'h0, rd_cmp} :
                            hit_flags ? {30'h0, overflow_flag_ff, compare_flag_ff} :
                            hit_en    ? {30'h0, overflow_irq_enable_ff, compare_irq_enable_ff} :
                            hit_port  ? {30'h0, pin_direction_bit_ff, port_val_ff} : 32'h0;

    // Crystal synchroniser and edge detect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xtal_meta_ff <= 1'b0;
            xtal_sync_ff <= 1'b0;
            xtal_prev_ff <= 1'b0;
        end else begin
            xtal_meta_ff <= crystal_in_pin;
            xtal_sync_ff <= xtal_meta_ff;
            xtal_prev_ff <= xtal_sync_ff;
        end
    end

    // APB response
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0;
        end else begin
            pready_ff  <= setup;
            pslverr_ff <= setup & ~mapped;
            if (setup & ~pwrite) begin
                prdata_ff <= rd_data;
            end
        end
    end

    // Control and configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff                <= CTRL_RESET;
            compare_irq_enable_ff  <= 1'b0;
            overflow_irq_enable_ff <= 1'b0;
            port_val_ff            <= 1'b0;
            pin_direction_bit_ff   <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= ctrl_wr;
            end
            if (wr_en) begin
                compare_irq_enable_ff  <= pwdata[EN_CMP_BIT];
                overflow_irq_enable_ff <= pwdata[EN_OVF_BIT];
            end
            if (wr_port) begin
                port_val_ff          <= pwdata[PORT_VAL_BIT];
                pin_direction_bit_ff <= pwdata[PORT_DIR_BIT];
            end
        end
    end

    // Compare value, buffer and active copy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_buf_ff   <= 8'h00;
            compare_value_ff <= 8'h00;
        end else begin
            if (wr_cmp) begin
                compare_buf_ff <= pwdata[7:0];
            end
            if (wr_cmp & ~pwm) begin
                compare_value_ff <= pwdata[7:0];
            end else if (pwm & top_ev) begin
                compare_value_ff <= compare_buf_ff;
            end
        end
    end

    // Counter, direction and match blocking
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_value_ff <= 8'h00;
            dir_ff         <= DIR_UP;
            block_ff       <= 1'b0;
        end else begin
            count_value_ff <= nxt_count_value;
            if (tick) begin
                dir_ff <= go_down ? DIR_DOWN : DIR_UP;
            end
            block_ff <= wr_count | (block_ff & ~tick);
        end
    end

    // Flags, compare output and registered outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_flag_ff   <= 1'b0;
            overflow_flag_ff  <= 1'b0;
            compare_output_ff <= 1'b0;
            compare_irq_ff    <= 1'b0;
            overflow_irq_ff   <= 1'b0;
            pin_out_ff        <= 1'b0;
            pin_oe_ff         <= 1'b0;
        end else begin
            compare_flag_ff   <= nxt_compare_flag;
            overflow_flag_ff  <= nxt_overflow_flag;
            compare_output_ff <= nxt_compare_output;
            compare_irq_ff    <= nxt_compare_flag & compare_irq_enable_ff;
            overflow_irq_ff   <= nxt_overflow_flag & overflow_irq_enable_ff;
            pin_out_ff        <= (com != COM_OFF) ? compare_output_ff : port_val_ff;
            pin_oe_ff         <= pin_direction_bit_ff;
        end
    end

    // Output drive
    assign prdata                = prdata_ff;
    assign pready                = pready_ff;
    assign pslverr               = pslverr_ff;
    assign compare_irq           = compare_irq_ff;
    assign overflow_irq          = overflow_irq_ff;
    assign compare_output_pin    = pin_out_ff;
    assign compare_output_pin_oe = pin_oe_ff;

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_count_write;
        wr_count;
    endsequence

    sequence s_blocked_tick;
        tick && block_ff && !compare_flag_ff;
    endsequence

    stop_hold_a: assert property (
        (ctrl_ff.clock_select_field == CS_STOP) && !wr_count |=> $stable(count_value_ff))
        else $error("stopped counter moved");

    write_prio_a: assert property (
        s_count_write |=> count_value_ff == $past(pwdata[7:0]))
        else $error("count write lost");

    cmp_flag_a: assert property (
        tick && match && !block_ff |=> compare_flag_ff ##1 compare_irq == compare_irq_enable_ff)
        else $error("compare flag or request missing");

    match_block_a: assert property (
        s_blocked_tick |=> !compare_flag_ff)
        else $error("match after count write not blocked");

    force_out_a: assert property (
        force_hit && ctrl_wr.compare_output_mode_field == COM_TOGGLE && !match_ev && !wr_count
        |=> compare_output_ff != $past(compare_output_ff) && count_value_ff == $past(count_value_ff))
        else $error("force strobe misbehaved");

    normal_wrap_a: assert property (
        tick && wgm == WGM_NORMAL && at_max && !wr_count |=> count_value_ff == CNT_BOTTOM && overflow_flag_ff)
        else $error("normal wrap or overflow wrong");

    com_zero_a: assert property (
        com == COM_OFF && !force_hit |=> $stable(compare_output_ff))
        else $error("output changed with mode zero");

    pin_mux_a: assert property (
        com != COM_OFF |=> compare_output_pin == $past(compare_output_ff) ##1 compare_output_pin_oe == $past(pin_direction_bit_ff))
        else $error("pin override wrong");

    direct_cmp_a: assert property (
        wr_cmp && !pwm |=> compare_value_ff == $past(pwdata[7:0]))
        else $error("direct compare write lost");

    block_set_a: assert property (
        s_count_write |=> block_ff)
        else $error("count write did not arm match blocking");

    cmp_ack_a: assert property (
        compare_irq_ack && !match_ev |=> !compare_flag_ff)
        else $error("compare flag not cleared by acknowledge");

    ovf_ack_a: assert property (
        overflow_irq_ack && !ovf_ev |=> !overflow_flag_ff)
        else $error("overflow flag not cleared by acknowledge");

    ctc_clear_a: assert property (
        tick && wgm == WGM_CTC && match && !wr_count |=> count_value_ff == CNT_BOTTOM)
        else $error("clear on match missing");

    fast_wrap_a: assert property (
        tick && wgm == WGM_FAST && at_max && !wr_count |=> count_value_ff == CNT_BOTTOM)
        else $error("fast PWM restart wrong");

    pc_turn_a: assert property (
        tick && wgm == WGM_PCPWM && at_max && !wr_count |=> count_value_ff == 8'(CNT_MAX - CNT_ONE))
        else $error("phase correct turn at top wrong");

    buf_hold_a: assert property (
        wr_cmp && pwm && !top_ev |=> $stable(compare_value_ff) && compare_buf_ff == $past(pwdata[7:0]))
        else $error("buffered compare write leaked");

    mode_keep_a: assert property (
        wr_ctrl && !force_hit && !match_ev && !top_ev |=> $stable(compare_output_ff))
        else $error("output state lost on mode change");

endmodule

// File: test/pin_load.sv
`timescale 1ns/1ps
// Load on the compare output pin, held low by a weak pull-down
module pin_load (
    // Pin driver from the block
    input  wire logic pin,
    input  wire logic pin_oe,
    // Level seen on the board
    output logic      line
);
    // Released pin falls to the pull-down level
    assign line = pin_oe ? pin : 1'b0;
endmodule

// File: test/timer8_tb.sv
`timescale 1ns/1ps
module timer8_tb
    import timer8_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite;
    logic        crystal_in_pin, compare_irq_ack, overflow_irq_ack;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, compare_irq, overflow_irq;
    logic        compare_output_pin, compare_output_pin_oe, line, last_err;
    logic [7:0]  c;
    logic [1:0]  com;
    logic [1:0]  wgms [4] = '{WGM_NORMAL, WGM_CTC, WGM_FAST, WGM_PCPWM};
    logic [1:0]  coms [4] = '{COM_CLEAR, COM_TOGGLE, COM_TOGGLE, COM_SET};
    logic [7:0]  offs [6] = '{OFF_CTRL, OFF_COUNT, OFF_COMPARE, OFF_FLAGS, OFF_IRQ_EN, OFF_PORT};
    int          fail_count, tests_run, seed;

    timer8 timer8_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .crystal_in_pin(crystal_in_pin), .compare_irq_ack(compare_irq_ack),
        .overflow_irq_ack(overflow_irq_ack), .compare_irq(compare_irq), .overflow_irq(overflow_irq),
        .compare_output_pin(compare_output_pin), .compare_output_pin_oe(compare_output_pin_oe));

    pin_load pin_load_i (.pin(compare_output_pin), .pin_oe(compare_output_pin_oe), .line(line));

    // 40 MHz bus clock
    always #12.5 pclk = ~pclk;

    // Control word builder
    function automatic logic [31:0] mk(logic f, logic a, logic [1:0] cm, logic [1:0] w, logic [2:0] cs);
        return {22'h0, f, a, 1'b0, cm, w, cs};
    endfunction

    task stop_test;
        if (fail_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One APB transfer, entered just after a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r        = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Crystal rising edges, slow enough for the synchroniser
    task ticks(input int n);
        repeat (n) begin
            crystal_in_pin <= 1'b1;
            repeat (4) @(posedge pclk);
            crystal_in_pin <= 1'b0;
            repeat (4) @(posedge pclk);
        end
        repeat (4) @(posedge pclk);
    endtask

    // Board level after the registered pin settles
    task pin_chk(input logic exp);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk("line", {31'h0, exp}, {31'h0, line});
        @(posedge pclk);
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        stop_test();
    end

    initial begin
        {pclk, presetn, psel, penable, pwrite, crystal_in_pin, compare_irq_ack, overflow_irq_ack} = '0;
        paddr  = '0;
        pwdata = '0;
        seed   = 32'h68a5;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Reset values and an unmapped place
        foreach (offs[i]) begin
            apb(1'b0, offs[i], 32'h0, rd);
            chk("reset_reg", 32'h0, rd);
        end
        apb(1'b0, 8'h18, 32'h0, rd);
        chk("slverr", 32'h1, {31'h0, last_err});
        // Stopped counter stays put but is writable
        c = 8'($random(seed));
        apb(1'b1, OFF_COUNT, {24'h0, c}, rd);
        repeat (10) @(posedge pclk);
        apb(1'b0, OFF_COUNT, 32'h0, rd);
        chk("count_stop", {24'h0, c}, rd);
        // Count sequence per waveform mode, crystal ticks
        apb(1'b1, OFF_IRQ_EN, 32'h3, rd);
        foreach (wgms[i]) begin
            com = 2'($random(seed));
            apb(1'b1, OFF_CTRL, mk(1'b0, 1'b1, com, wgms[i], 3'h1), rd);
            apb(1'b1, OFF_COMPARE, (wgms[i] == WGM_CTC) ? 32'hFF : 32'h80, rd);
            apb(1'b1, OFF_COUNT, 32'hFE, rd);
            ticks(2);
            apb(1'b0, OFF_COUNT, 32'h0, rd);
            chk("count_seq", (wgms[i] == WGM_PCPWM) ? 32'hFE : 32'h0, rd);
            apb(1'b0, OFF_FLAGS, 32'h0, rd);
            chk("ovf_flag", {31'h0, wgms[i] != WGM_PCPWM}, {31'h0, rd[FLAG_OVF_BIT]});
            chk("ovf_irq", {31'h0, wgms[i] != WGM_PCPWM}, {31'h0, overflow_irq});
            if (i[0]) begin
                apb(1'b1, OFF_FLAGS, 32'h3, rd);
            end else begin
                {compare_irq_ack, overflow_irq_ack} <= 2'b11;
                @(posedge pclk);
                {compare_irq_ack, overflow_irq_ack} <= 2'b00;
                @(posedge pclk);
            end
            apb(1'b0, OFF_FLAGS, 32'h0, rd);
            chk("flags_clr", 32'h0, rd);
        end
        // Compare match, suppression after a count write, interrupt
        c = 8'($random(seed));
        apb(1'b1, OFF_CTRL, mk(1'b0, 1'b1, COM_OFF, WGM_NORMAL, 3'h1), rd);
        apb(1'b1, OFF_COMPARE, {24'h0, c}, rd);
        apb(1'b1, OFF_COUNT, {24'h0, c}, rd);
        ticks(1);
        apb(1'b0, OFF_FLAGS, 32'h0, rd);
        chk("cmp_blocked", 32'h0, {31'h0, rd[FLAG_CMP_BIT]});
        apb(1'b1, OFF_COUNT, {24'h0, c - 8'h01}, rd);
        ticks(1);
        apb(1'b0, OFF_FLAGS, 32'h0, rd);
        chk("cmp_early", 32'h0, {31'h0, rd[FLAG_CMP_BIT]});
        ticks(1);
        apb(1'b0, OFF_FLAGS, 32'h0, rd);
        chk("cmp_flag", 32'h1, {31'h0, rd[FLAG_CMP_BIT]});
        chk("cmp_irq", 32'h1, {31'h0, compare_irq});
        compare_irq_ack <= 1'b1;
        @(posedge pclk);
        compare_irq_ack <= 1'b0;
        @(posedge pclk);
        apb(1'b0, OFF_FLAGS, 32'h0, rd);
        chk("cmp_ack", 32'h0, {31'h0, rd[FLAG_CMP_BIT]});
        // Forced compare sets up the pin before it drives
        apb(1'b1, OFF_FLAGS, 32'h3, rd);
        apb(1'b1, OFF_CTRL, mk(1'b1, 1'b0, COM_SET, WGM_NORMAL, CS_STOP), rd);
        apb(1'b1, OFF_PORT, 32'h2, rd);
        pin_chk(1'b1);
        foreach (coms[i]) begin
            apb(1'b1, OFF_CTRL, mk(1'b1, 1'b0, coms[i], WGM_NORMAL, CS_STOP), rd);
            pin_chk(i[0]);
        end
        apb(1'b0, OFF_FLAGS, 32'h0, rd);
        chk("force_flag", 32'h0, rd);
        apb(1'b0, OFF_COUNT, 32'h0, rd);
        chk("force_count", {24'h0, c + 8'h01}, rd);
        // Output state survives mode change
        apb(1'b1, OFF_CTRL, mk(1'b0, 1'b0, COM_SET, WGM_FAST, CS_STOP), rd);
        pin_chk(1'b1);
        // Output mode zero hands the pin back to the port
        apb(1'b1, OFF_CTRL, mk(1'b0, 1'b0, COM_OFF, WGM_NORMAL, CS_STOP), rd);
        pin_chk(1'b0);
        apb(1'b1, OFF_PORT, 32'h3, rd);
        pin_chk(1'b1);
        apb(1'b1, OFF_CTRL, mk(1'b0, 1'b0, COM_CLEAR, WGM_NORMAL, CS_STOP), rd);
        apb(1'b1, OFF_PORT, 32'h1, rd);
        pin_chk(1'b0);
        stop_test();
    end
endmodule
